// ===== design/gpiop_port.sv
// General purpose port block: 22 pins, pulls, open drain, wake-up and
// external interrupt events, registers over an AHB-Lite slave.
// Assumes one clock, pad inputs synchronous to it, one slave on the bus.
//
// Functional notes
// - Twenty-two pins across ports A, B, C, I
// - Direction bit one drives, zero receives
// - Data read gives pins, write sets latch
// - Open drain on A, B, C drives low only
// - Pull register: pull-up high, pull-down low
// - Strength bit one picks weak pull-down
// - Weak pull-down turns off other pull-downs
// - Strong pull-down with high input selects it
// - Enabled pins on A, B, C raise wake
// - Edge bit one rising, zero falling
// - Port B bits zero to three: both edges
// - Two pin pairs act as external interrupts
// - Timer trigger selects force two pins input
// - Alternate functions override plain port use
`timescale 1ns/1ns
`include "gpiop_cfg.svh"

module gpiop_port (
  // Clock, reset, enable
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   clk_en_in,
  // AHB-Lite slave
  input  wire logic                   hsel_in,
  input  wire logic [31:0]            haddr_in,
  input  wire logic [1:0]             htrans_in,
  input  wire logic                   hwrite_in,
  input  wire logic [2:0]             hsize_in,
  input  wire logic [31:0]            hwdata_in,
  input  wire logic                   hready_in,
  output logic      [31:0]            hrdata_out,
  output logic                        hreadyout_out,
  output logic                        hresp_out,
  // Pads
  input  wire gpiop_pkg::gpiop_pins_t pad_in_in,
  output gpiop_pkg::gpiop_pins_t      pad_out_out,
  output gpiop_pkg::gpiop_pins_t      pad_oe_out,
  // Alternate functions
  input  wire gpiop_pkg::gpiop_pins_t alt_out_in,
  input  wire gpiop_pkg::gpiop_pins_t alt_oe_in,
  // Pull resistor controls, ports A, B, C
  output logic [`GPIOP_NUM_WAKE-1:0]  pull_up_en_out,
  output logic [`GPIOP_NUM_WAKE-1:0]  pd_strong_en_out,
  output logic [`GPIOP_NUM_WAKE-1:0]  pd_weak_en_out,
  output logic [`GPIOP_NUM_WAKE-1:0]  pd_keep_en_out,
  // Events
  output logic                        wake_out,
  output logic                        irq_out
);

  localparam int NP = `GPIOP_NUM_PINS;
  localparam int NW = `GPIOP_NUM_WAKE;

  function automatic logic [11:0] addr_of(input logic [1:0] sp, input logic [5:0] idx);
    addr_of = {2'h0, sp, idx, 2'h0};
  endfunction : addr_of

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in || !clk_en_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes commit with no wait, reads take one wait state so that
  // the read data leaves a flip-flop and a write just before is already seen.

  gpiop_pkg::gpiop_bus_state_t bus_reg, bus_next;
  logic [11:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic        hready_reg;
  logic [31:0] rd_data;

  wire acc    = hsel_in && htrans_in[1] && hready_in;
  wire wr_go  = (bus_reg == gpiop_pkg::GPIOP_BUS_WR);
  wire rd_cap = (bus_reg == gpiop_pkg::GPIOP_BUS_RD_WAIT);

  always_comb begin
    bus_next = bus_reg;
    unique case (bus_reg)
      gpiop_pkg::GPIOP_BUS_RD_WAIT: bus_next = gpiop_pkg::GPIOP_BUS_RD_DONE;
      gpiop_pkg::GPIOP_BUS_IDLE,
      gpiop_pkg::GPIOP_BUS_RD_DONE,
      gpiop_pkg::GPIOP_BUS_WR: begin
        if (!acc)
          bus_next = gpiop_pkg::GPIOP_BUS_IDLE;
        else if (hwrite_in)
          bus_next = gpiop_pkg::GPIOP_BUS_WR;
        else
          bus_next = gpiop_pkg::GPIOP_BUS_RD_WAIT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_reg     <= gpiop_pkg::GPIOP_BUS_IDLE;
      dp_addr_reg <= 12'h000;
      hrdata_reg  <= `GPIOP_RST_RDATA;
      hready_reg  <= 1'b1;
    end else if (clk_en_in) begin
      bus_reg    <= bus_next;
      hready_reg <= (bus_next != gpiop_pkg::GPIOP_BUS_RD_WAIT);
      if (acc)
        dp_addr_reg <= haddr_in[11:0];
      if (rd_cap)
        hrdata_reg <= rd_data;
    end
  end

  assign hrdata_out    = hrdata_reg;
  assign hreadyout_out = hready_reg;
  assign hresp_out     = 1'b0;

  sequence s_rd_pa_data;
    acc && !hwrite_in && (haddr_in[11:0] == addr_of(`GPIOP_SP_COMMON, `GPIOP_IDX_PA_DATA));
  endsequence
  sequence s_rd_answer;
    !hready_reg ##1 hready_reg;
  endsequence
  property p_read_pins;
    s_rd_pa_data |=> s_rd_answer ##0 (hrdata_reg[5:0] == $past(s2_reg[5:0]));
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("pin data read wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sampling; only the second and third stages are looked at

  logic [NP-1:0] s1_reg, s2_reg, prev_reg;
  wire  [NP-1:0] pad_in_vec = pad_in_in;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      prev_reg <= '0;
    end else if (clk_en_in) begin
      s1_reg   <= pad_in_vec;
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port control registers, ports A, B, C

  logic [NP-1:0]      dir_vec, out_vec;
  logic [NW-1:0]      od_vec, pds_vec, wen_vec, wedge_vec, pu_vec, pd_vec;
  logic [2:0][31:0]   rd_port;
  logic [1:0]         pi_dir_reg, pi_out_reg;

  for (genvar p = 0; p < 3; p++) begin : g_port
    localparam int LSB = (p == 0) ? 0 : ((p == 1) ? `GPIOP_NUM_A : `GPIOP_NUM_A + `GPIOP_NUM_B);
    localparam int W   = (p == 2) ? `GPIOP_NUM_C : `GPIOP_NUM_A;
    localparam logic [5:0] PULL_IDX = (p == 0) ? `GPIOP_IDX_PA_PULL :
                                      ((p == 1) ? `GPIOP_IDX_PB_PULL : `GPIOP_IDX_PC_PULL);
    logic [W-1:0] dir_reg, out_reg, od_reg, pds_reg, wen_reg, wedge_reg, pu_reg, pd_reg;

    wire [5:0] off       = 6'(p);
    wire       sel_dir   = dp_addr_reg == addr_of(`GPIOP_SP_COMMON, `GPIOP_IDX_PA_DIR + off);
    wire       sel_dat   = dp_addr_reg == addr_of(`GPIOP_SP_COMMON, `GPIOP_IDX_PA_DATA + off);
    wire       sel_pull  = dp_addr_reg == addr_of(`GPIOP_SP_COMMON, PULL_IDX);
    wire       sel_od    = dp_addr_reg == addr_of(`GPIOP_SP_VIRTUAL, `GPIOP_IDX_PA_OD + off);
    wire       sel_pds   = dp_addr_reg == addr_of(`GPIOP_SP_VIRTUAL, `GPIOP_IDX_PA_PDS + off);
    wire       sel_wen   = dp_addr_reg == addr_of(`GPIOP_SP_VIRTUAL, `GPIOP_IDX_PA_WEN + off);
    wire       sel_wedge = dp_addr_reg == addr_of(`GPIOP_SP_VIRTUAL, `GPIOP_IDX_PA_WEDGE + off);
    wire [1:0] hi_dir    = (p == 2) ? pi_dir_reg : 2'h0;
    wire [1:0] hi_pin    = (p == 2) ? s2_reg[NP-1 -: 2] : 2'h0;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        dir_reg   <= '0;
        out_reg   <= '0;
        od_reg    <= '0;
        pds_reg   <= '0;
        wen_reg   <= '0;
        wedge_reg <= '0;
        pu_reg    <= '0;
        pd_reg    <= '0;
      end else if (clk_en_in) begin
        if (wr_go && sel_dir)
          dir_reg <= hwdata_in[W-1:0];
        if (wr_go && sel_dat)
          out_reg <= hwdata_in[W-1:0];
        if (wr_go && sel_od)
          od_reg <= hwdata_in[W-1:0];
        if (wr_go && sel_pds)
          pds_reg <= hwdata_in[W-1:0];
        if (wr_go && sel_wen)
          wen_reg <= hwdata_in[W-1:0];
        if (wr_go && sel_wedge)
          wedge_reg <= hwdata_in[W-1:0];
        if (wr_go && sel_pull) begin
          pu_reg <= hwdata_in[`GPIOP_HI_LSB +: W];
          pd_reg <= hwdata_in[W-1:0];
        end
      end
    end

    assign dir_vec[LSB +: W]   = dir_reg;
    assign out_vec[LSB +: W]   = out_reg;
    assign od_vec[LSB +: W]    = od_reg;
    assign pds_vec[LSB +: W]   = pds_reg;
    assign wen_vec[LSB +: W]   = wen_reg;
    assign wedge_vec[LSB +: W] = wedge_reg;
    assign pu_vec[LSB +: W]    = pu_reg;
    assign pd_vec[LSB +: W]    = pd_reg;

    // Strength, wake enable and wake edge are write-only and read as zero
    assign rd_port[p] = ({32{sel_dir}}  & {16'h0000, hi_dir, 6'h00, 8'(dir_reg)}) |
                        ({32{sel_dat}}  & {16'h0000, hi_pin, 6'h00, 8'(s2_reg[LSB +: W])}) |
                        ({32{sel_od}}   & {24'h00_0000, 8'(od_reg)}) |
                        ({32{sel_pull}} & {16'h0000, 8'(pu_reg), 8'(pd_reg)});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port I, double edge, local registers

  logic [`GPIOP_NUM_DBL-1:0] dbl_reg;
  logic [1:0]                trig_reg;
  logic [NP-1:0]             alt_reg, mask_reg, status_reg;

  wire sel_pci_dir  = dp_addr_reg == addr_of(`GPIOP_SP_COMMON, `GPIOP_IDX_PCI_DIR);
  wire sel_pci_data = dp_addr_reg == addr_of(`GPIOP_SP_COMMON, `GPIOP_IDX_PCI_DATA);
  wire sel_dbl      = dp_addr_reg == addr_of(`GPIOP_SP_VIRTUAL, `GPIOP_IDX_PB_DBL);
  wire sel_stat     = dp_addr_reg == addr_of(`GPIOP_SP_LOCAL, `GPIOP_IDX_IRQ_STAT);
  wire sel_mask     = dp_addr_reg == addr_of(`GPIOP_SP_LOCAL, `GPIOP_IDX_IRQ_MASK);
  wire sel_trig     = dp_addr_reg == addr_of(`GPIOP_SP_LOCAL, `GPIOP_IDX_TRIG);
  wire sel_alt      = dp_addr_reg == addr_of(`GPIOP_SP_LOCAL, `GPIOP_IDX_ALT);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pi_dir_reg <= 2'h0;
      pi_out_reg <= 2'h0;
      dbl_reg    <= 4'h0;
      trig_reg   <= 2'h0;
      alt_reg    <= NP'(`GPIOP_RST_CTRL);
      mask_reg   <= NP'(`GPIOP_RST_CTRL);
    end else if (clk_en_in) begin
      if (wr_go && sel_pci_dir)
        pi_dir_reg <= hwdata_in[`GPIOP_PI_LSB +: 2];
      if (wr_go && sel_pci_data)
        pi_out_reg <= hwdata_in[`GPIOP_PI_LSB +: 2];
      if (wr_go && sel_dbl)
        dbl_reg <= hwdata_in[`GPIOP_NUM_DBL-1:0];
      if (wr_go && sel_trig)
        trig_reg <= hwdata_in[1:0];
      if (wr_go && sel_alt)
        alt_reg <= hwdata_in[NP-1:0];
      if (wr_go && sel_mask)
        mask_reg <= hwdata_in[NP-1:0];
    end
  end

  assign dir_vec[NP-1 -: 2] = pi_dir_reg;
  assign out_vec[NP-1 -: 2] = pi_out_reg;

  assign rd_data = rd_port[0] | rd_port[1] | rd_port[2] |
                   ({32{sel_stat}} & 32'(status_reg)) |
                   ({32{sel_mask}} & 32'(mask_reg)) |
                   ({32{sel_trig}} & 32'(trig_reg)) |
                   ({32{sel_alt}}  & 32'(alt_reg));

  ////////////////////////////////////////////////////////////////////////////////
  // Pad drive: alternate function first, then forced input, then open drain

  logic [NP-1:0] force_in, dir_eff, od_full, pad_out_reg, pad_oe_reg;

  always_comb begin
    force_in = '0;
    force_in[`GPIOP_PIN_B2] = trig_reg[0];
    force_in[`GPIOP_PIN_C7] = trig_reg[1];
  end

  assign dir_eff = dir_vec & ~force_in;
  assign od_full = {2'h0, od_vec};

  // An open-drain pin drives low only while its latch is zero
  wire [NP-1:0] gp_out = out_vec & ~od_full;
  wire [NP-1:0] gp_oe  = dir_eff & ~(od_full & out_vec);
  wire [NP-1:0] alt_o  = alt_out_in;
  wire [NP-1:0] alt_e  = alt_oe_in;

  // Pull-down paths: weak one excludes the strong one and the keeper
  wire [NW-1:0] pd_weak   = pd_vec & pds_vec;
  wire [NW-1:0] pd_strong = pd_vec & ~pds_vec & s2_reg[NW-1:0];
  wire [NW-1:0] pd_keep   = pd_vec & ~pds_vec & ~s2_reg[NW-1:0];

  logic [NW-1:0] pu_reg_o, pd_strong_reg, pd_weak_reg, pd_keep_reg;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_out_reg   <= '0;
      pad_oe_reg    <= '0;
      pu_reg_o      <= '0;
      pd_strong_reg <= '0;
      pd_weak_reg   <= '0;
      pd_keep_reg   <= '0;
    end else if (clk_en_in) begin
      pad_out_reg   <= (alt_reg & alt_o) | (~alt_reg & gp_out);
      pad_oe_reg    <= (alt_reg & alt_e) | (~alt_reg & gp_oe);
      pu_reg_o      <= pu_vec;
      pd_strong_reg <= pd_strong;
      pd_weak_reg   <= pd_weak;
      pd_keep_reg   <= pd_keep;
    end
  end

  assign pad_out_out      = pad_out_reg;
  assign pad_oe_out       = pad_oe_reg;
  assign pull_up_en_out   = pu_reg_o;
  assign pd_strong_en_out = pd_strong_reg;
  assign pd_weak_en_out   = pd_weak_reg;
  assign pd_keep_en_out   = pd_keep_reg;

  property p_dir_input;
    1 |=> (pad_oe_reg & ~$past(alt_reg) & ~$past(dir_vec)) == '0;
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input pin driven");

  property p_open_drain;
    1 |=> (pad_out_reg & ~$past(alt_reg) & $past(od_full)) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_force_input;
    trig_reg[0] && !alt_reg[`GPIOP_PIN_B2] |=> !pad_oe_reg[`GPIOP_PIN_B2];
  endproperty
  a_force_input: assert property (p_force_input) else $error("forced pin driven");

  property p_pd_weak;
    1 |=> (pd_weak_reg & (pd_strong_reg | pd_keep_reg)) == '0;
  endproperty
  a_pd_weak: assert property (p_pd_weak) else $error("pull-downs overlap");

  property p_pd_strong;
    (pd_vec[0] && !pds_vec[0] && s2_reg[0]) |=> pd_strong_reg[0] && !pd_weak_reg[0];
  endproperty
  a_pd_strong: assert property (p_pd_strong) else $error("strong pull-down missing");

  ////////////////////////////////////////////////////////////////////////////////
  // Wake and interrupt events; status is sticky and cleared by its read

  wire [NW-1:0] rise = s2_reg[NW-1:0] & ~prev_reg[NW-1:0];
  wire [NW-1:0] fall = ~s2_reg[NW-1:0] & prev_reg[NW-1:0];
  logic [NW-1:0] dbl_vec;

  always_comb begin
    dbl_vec = '0;
    dbl_vec[`GPIOP_DBL_LSB +: `GPIOP_NUM_DBL] = dbl_reg;
  end

  wire [NW-1:0] edge_sel = (wedge_vec & rise) | (~wedge_vec & fall);
  wire [NW-1:0] wake_hit = wen_vec & ((dbl_vec & (rise | fall)) | (~dbl_vec & edge_sel));
  wire ext0 = rise[`GPIOP_PIN_B3] | rise[`GPIOP_PIN_C6];
  wire ext1 = rise[`GPIOP_PIN_C3] | rise[`GPIOP_PIN_B1];
  wire [NP-1:0] evt   = {ext1, ext0, wake_hit};
  wire [NP-1:0] clr   = {NP{rd_cap && sel_stat}};
  logic wake_reg, irq_reg;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg <= '0;
      wake_reg   <= 1'b0;
      irq_reg    <= 1'b0;
    end else if (clk_en_in) begin
      status_reg <= (status_reg & ~clr) | evt; // Set wins over a clearing read
      wake_reg   <= |wake_hit;
      irq_reg    <= |(status_reg & mask_reg);
    end
  end

  assign wake_out = wake_reg;
  assign irq_out  = irq_reg;

  property p_wake_rise;
    (wen_vec[0] && wedge_vec[0] && rise[0]) |=> status_reg[0] && wake_reg;
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("rising wake lost");

  property p_wake_wrong_edge;
    (!wedge_vec[0] && !fall[0] && !status_reg[0]) |=> !status_reg[0];
  endproperty
  a_wake_wrong_edge: assert property (p_wake_wrong_edge) else $error("wake on rising");

  property p_wake_off;
    (!wen_vec[3] && !status_reg[3]) |=> !status_reg[3];
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("disabled pin woke");

  property p_double_edge;
    (wen_vec[`GPIOP_DBL_LSB] && dbl_reg[0] && fall[`GPIOP_DBL_LSB])
      |=> status_reg[`GPIOP_DBL_LSB];
  endproperty
  a_double_edge: assert property (p_double_edge) else $error("double edge lost");

  property p_sync_delay;
    $rose(status_reg[0]) |-> $past(pad_in_vec[0], 3) != $past(pad_in_vec[0], 4);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("wake not synchronised");

  property p_ext_int;
    rise[`GPIOP_PIN_B3] |=> status_reg[`GPIOP_EVT_EXT0];
  endproperty
  a_ext_int: assert property (p_ext_int) else $error("external interrupt lost");

  property p_irq_level;
    ((status_reg & mask_reg) != '0) |=> irq_reg;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  // hsize is not decoded: only whole-word transfers are expected
  wire unused_ok = &{1'b0, hsize_in, haddr_in[31:12]};

endmodule : gpiop_port

// ===== inc/gpiop_cfg.svh
// Register map, field positions and reset values of the general purpose port block.
// Definitions only; included by the package and by the port module.
`ifndef GPIOP_CFG_SVH
`define GPIOP_CFG_SVH

// Pin counts per port
`define GPIOP_NUM_A        6
`define GPIOP_NUM_B        6
`define GPIOP_NUM_C        8
`define GPIOP_NUM_I        2
`define GPIOP_NUM_PINS     22
`define GPIOP_NUM_WAKE     20
`define GPIOP_NUM_EVT      22
`define GPIOP_NUM_DBL      4

// Register spaces, byte address bits [9:8]
`define GPIOP_SP_COMMON    2'h0
`define GPIOP_SP_VIRTUAL   2'h1
`define GPIOP_SP_LOCAL     2'h2

// Common space indexes
`define GPIOP_IDX_PA_DIR   6'h04
`define GPIOP_IDX_PB_DIR   6'h05
`define GPIOP_IDX_PCI_DIR  6'h06
`define GPIOP_IDX_PA_DATA  6'h07
`define GPIOP_IDX_PB_DATA  6'h08
`define GPIOP_IDX_PCI_DATA 6'h09
`define GPIOP_IDX_PA_PULL  6'h15
`define GPIOP_IDX_PB_PULL  6'h1a
`define GPIOP_IDX_PC_PULL  6'h1b

// Virtual space indexes
`define GPIOP_IDX_PA_OD    6'h05
`define GPIOP_IDX_PA_PDS   6'h0d
`define GPIOP_IDX_PA_WEN   6'h10
`define GPIOP_IDX_PA_WEDGE 6'h13
`define GPIOP_IDX_PB_DBL   6'h16

// Local space indexes
`define GPIOP_IDX_IRQ_STAT 6'h00
`define GPIOP_IDX_IRQ_MASK 6'h01
`define GPIOP_IDX_TRIG     6'h02
`define GPIOP_IDX_ALT      6'h03

// Field positions
`define GPIOP_HI_LSB       8
`define GPIOP_PI_LSB       14
`define GPIOP_PIN_B1       7
`define GPIOP_PIN_B2       8
`define GPIOP_PIN_B3       9
`define GPIOP_PIN_C3       15
`define GPIOP_PIN_C6       18
`define GPIOP_PIN_C7       19
`define GPIOP_DBL_LSB      6
`define GPIOP_EVT_EXT0     20
`define GPIOP_EVT_EXT1     21

// Reset values
`define GPIOP_RST_CTRL     32'h0000_0000
`define GPIOP_RST_RDATA    32'h0000_0000

`endif

// ===== inc/gpiop_pkg.sv
// Types shared by the general purpose port block and its bench.
// Assumes gpiop_cfg.svh is on the include path.
`include "gpiop_cfg.svh"

package gpiop_pkg;

  // One bit per pin; bit 0 is port A bit 0, bit 21 is port I bit 1
  typedef struct packed {
    logic [`GPIOP_NUM_I-1:0] port_i;
    logic [`GPIOP_NUM_C-1:0] port_c;
    logic [`GPIOP_NUM_B-1:0] port_b;
    logic [`GPIOP_NUM_A-1:0] port_a;
  } gpiop_pins_t;

  // Bus data phase states, Gray along idle, read wait, read done
  typedef enum logic [1:0] {
    GPIOP_BUS_IDLE    = 2'h0,
    GPIOP_BUS_RD_WAIT = 2'h1,
    GPIOP_BUS_RD_DONE = 2'h3,
    GPIOP_BUS_WR      = 2'h2
  } gpiop_bus_state_t;

endpackage : gpiop_pkg

// ===== testbench/gpiop_pads.sv
// Pin model: outside drivers, pull resistors and floating pads.
// Assumes pads A, B, C carry pulls; the bench never fights a driving pad.
`timescale 1ns/1ns
module gpiop_pads (
  // Port block side
  input  wire gpiop_pkg::gpiop_pins_t pad_out_in,
  input  wire gpiop_pkg::gpiop_pins_t pad_oe_in,
  input  wire logic [21:0]            pu_in,
  input  wire logic [21:0]            pd_in,
  // Bench side
  input  wire logic                   clk_in,
  input  wire gpiop_pkg::gpiop_pins_t ext_val_in,
  input  wire gpiop_pkg::gpiop_pins_t ext_en_in,
  output gpiop_pkg::gpiop_pins_t      pin_out
);
  logic [21:0] float_reg = 22'h0;

  // A floating pad toggles so that no settled level passes by luck
  always @(posedge clk_in) float_reg <= ~float_reg;

  always_comb begin
    for (int i = 0; i < 22; i++) begin
      if (pad_oe_in[i]) pin_out[i] = pad_out_in[i];
      else if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
      else if (pu_in[i]) pin_out[i] = 1'b1;
      else if (pd_in[i]) pin_out[i] = 1'b0;
      else pin_out[i] = float_reg[i];
    end
  end
endmodule : gpiop_pads

// ===== testbench/tb_top.sv
// Self-checking bench of the general purpose port block over AHB-Lite.
// Assumes the pin model gpiop_pads drives every pad input.
`timescale 1ns/1ns
module tb_top;
  logic                   ref_clk_in = 1'b0;
  logic                   rst_n_in = 1'b0;
  logic [31:0]            haddr = 32'h0;
  logic [31:0]            hwdata = 32'h0;
  logic [31:0]            hrdata;
  logic [31:0]            rd;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic                   hready;
  logic                   wake;
  logic                   irq;
  logic [19:0]            pu;
  logic [19:0]            pds;
  logic [19:0]            pdw;
  logic [19:0]            pdk;
  gpiop_pkg::gpiop_pins_t pin;
  gpiop_pkg::gpiop_pins_t pad_out;
  gpiop_pkg::gpiop_pins_t pad_oe;
  gpiop_pkg::gpiop_pins_t ext_val = '0;
  gpiop_pkg::gpiop_pins_t ext_en = '1;
  gpiop_pkg::gpiop_pins_t alt_out = '0;
  gpiop_pkg::gpiop_pins_t alt_oe = '0;
  int                     miscompares = 0;
  int                     compares = 0;
  int                     wake_cnt = 0;

  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;

  gpiop_port u_gpiop_port (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(), .pad_in_in(pin), .pad_out_out(pad_out), .pad_oe_out(pad_oe),
    .alt_out_in(alt_out), .alt_oe_in(alt_oe), .pull_up_en_out(pu), .pd_strong_en_out(pds),
    .pd_weak_en_out(pdw), .pd_keep_en_out(pdk), .wake_out(wake), .irq_out(irq));

  gpiop_pads u_gpiop_pads (
    .pad_out_in(pad_out), .pad_oe_in(pad_oe), .pu_in({2'h0, pu}),
    .pd_in({2'h0, pds | pdw | pdk}), .clk_in(ref_clk_in), .ext_val_in(ext_val),
    .ext_en_in(ext_en), .pin_out(pin));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ad(input logic [1:0] sp, input logic [5:0] ix);
    return {22'h0, sp, ix, 2'h0};
  endfunction : ad

  task tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : tick

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // Holds each phase until hready is seen high; read data taken at that edge
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("oe", pad_oe, 32'h0);
    chk("pulls", pu | pds | pdw | pdk, 32'h0);
    wr(ad(2'h0, 6'h3f), 32'hffff);
    wr(ad(2'h1, 6'h10), 32'h3f);
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < 64; i++) begin
        if (s != 0 || i < 7 || i > 9) rdc("reg", ad(s[1:0], i[5:0]), 32'h0);
      end
    end
    $display("reset test done");
  endtask : t_reset

  task t_dir;
    wr(ad(2'h0, 6'h04), 32'h3f);
    wr(ad(2'h0, 6'h07), 32'h15);
    wr(ad(2'h0, 6'h06), 32'hc0ff);
    wr(ad(2'h0, 6'h09), 32'h8081);
    tick(2);
    chk("a oe", pad_oe.port_a, 32'h3f);
    chk("a out", pad_out.port_a, 32'h15);
    chk("ci oe", {pad_oe.port_i, pad_oe.port_c}, 32'h3ff);
    chk("ci out", {pad_out.port_i, pad_out.port_c}, 32'h281);
    rdc("a dir", ad(2'h0, 6'h04), 32'h3f);
    rdc("a pins", ad(2'h0, 6'h07), 32'h15);
    wr(ad(2'h0, 6'h04), 32'h0);
    wr(ad(2'h0, 6'h06), 32'h0);
    ext_val.port_a <= 6'h2a;
    tick(3);
    chk("a in", pad_oe.port_a, 32'h0);
    rdc("a pins in", ad(2'h0, 6'h07), 32'h2a);
    ext_val <= '0;
    $display("direction test done");
  endtask : t_dir

  task t_od;
    wr(ad(2'h0, 6'h05), 32'h3f);
    wr(ad(2'h0, 6'h08), 32'h05);
    wr(ad(2'h1, 6'h06), 32'h3f);
    tick(2);
    chk("od oe", pad_oe.port_b, 32'h3a);
    chk("od low", pad_out.port_b & pad_oe.port_b, 32'h0);
    rdc("od reg", ad(2'h1, 6'h06), 32'h3f);
    wr(ad(2'h1, 6'h06), 32'h0);
    tick(2);
    chk("push pull", pad_oe.port_b, 32'h3f);
    $display("open drain test done");
  endtask : t_od

  task t_pull;
    ext_en.port_c <= 8'h40;
    ext_val.port_c <= 8'h40;
    wr(ad(2'h0, 6'h1b), 32'h0ff0);
    wr(ad(2'h1, 6'h0f), 32'h30);
    tick(4);
    chk("pull up", pu[19:12], 32'h0f);
    chk("weak pd", pdw[19:12], 32'h30);
    chk("strong pd", pds[19:12], 32'h40);
    chk("keep pd", pdk[19:12], 32'h80);
    rdc("pull reg", ad(2'h0, 6'h1b), 32'h0ff0);
    rdc("c pins", ad(2'h0, 6'h09), 32'h4f);
    wr(ad(2'h0, 6'h1b), 32'h0);
    ext_en <= '1;
    ext_val <= '0;
    $display("pull test done");
  endtask : t_pull

  task t_trig;
    wr(ad(2'h0, 6'h06), 32'hff);
    wr(ad(2'h2, 6'h02), 32'h1);
    tick(2);
    chk("b2 forced", pad_oe.port_b, 32'h3b);
    chk("c7 free", pad_oe.port_c, 32'hff);
    wr(ad(2'h2, 6'h02), 32'h2);
    tick(2);
    chk("b2 free", pad_oe.port_b, 32'h3f);
    chk("c7 forced", pad_oe.port_c, 32'h7f);
    wr(ad(2'h2, 6'h02), 32'h0);
    wr(ad(2'h0, 6'h05), 32'h0);
    wr(ad(2'h0, 6'h06), 32'h0);
    alt_oe <= 22'h1;
    alt_out <= 22'h1;
    wr(ad(2'h2, 6'h03), 32'h1);
    tick(2);
    chk("alt pin", {pad_oe[0], pad_out[0]}, 32'h3);
    wr(ad(2'h2, 6'h03), 32'h0);
    tick(2);
    chk("alt off", pad_oe, 32'h0);
    $display("trigger and alternate test done");
  endtask : t_trig

  task ev(input logic [21:0] v, input logic [21:0] st, input logic [21:0] m);
    int c;
    c = wake_cnt;
    ext_val <= v;
    tick(6);
    chk("wake pulses", wake_cnt - c, {31'h0, st[19:0] != 20'h0});
    chk("irq", irq, {31'h0, (st & m) != 22'h0});
    rdc("status", ad(2'h2, 6'h00), st);
    tick(2);
    chk("irq clear", irq, 32'h0);
  endtask : ev

  task t_wake;
    logic [21:0] vs [16] = '{22'h1, 22'h3, 22'h1, 22'h0, 22'h4, 22'h0, 22'h40, 22'h0,
      22'h200, 22'h0, 22'h40000, 22'h0, 22'h8000, 22'h0, 22'h80, 22'h0};
    logic [21:0] ss [16] = '{22'h1, 22'h0, 22'h2, 22'h0, 22'h0, 22'h0, 22'h40, 22'h40,
      22'h100000, 22'h0, 22'h100000, 22'h0, 22'h200000, 22'h0, 22'h200000, 22'h0};
    wr(ad(2'h2, 6'h01), 32'h3fffff);
    wr(ad(2'h1, 6'h10), 32'h3);
    wr(ad(2'h1, 6'h13), 32'h1);
    wr(ad(2'h1, 6'h11), 32'h1);
    wr(ad(2'h1, 6'h16), 32'h1);
    tick(6);
    bus(1'b0, ad(2'h2, 6'h00), 32'h0);
    for (int i = 0; i < 16; i++) begin
      ev(vs[i], ss[i], 22'h3fffff);
    end
    wr(ad(2'h2, 6'h01), 32'h0);
    ev(22'h1, 22'h1, 22'h0);
    $display("wake test done");
  endtask : t_wake

  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    tick(1);
    t_reset;
    t_dir;
    t_od;
    t_pull;
    t_trig;
    t_wake;
    end_sim;
  end

  // The tests take about 1000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    miscompares++;
    end_sim;
  end
endmodule : tb_top
